// File: verilog/acs_pkg.sv
package acs_pkg;
  // Converter geometry
  localparam int CHANNELS   = 16;
  localparam int CH_W       = 4;
  localparam int CODE_STEPS = 4096;
  localparam int RES_W      = $clog2(CODE_STEPS);
  localparam int WORD_W     = 16;
  localparam int CTRL_W     = 12;

  // Field positions inside the received 16-bit word
  localparam int WR_BIT     = 15;
  localparam int AUTO_BIT   = 14;
  localparam int ADDR_HI    = 13;
  localparam int ADDR_LO    = 10;
  localparam int PM_HI      = 9;
  localparam int PM_LO      = 8;
  localparam int SHADOW_BIT = 7;
  localparam int RANGE_BIT  = 5;
  localparam int CODING_BIT = 4;
  localparam int CTRL_LO    = 4;

  // Serial frame timing, in falling serial clock edges
  localparam logic [3:0] EDGE_FIRST = 4'h0;
  localparam logic [3:0] EDGE_TRIAL = 4'h3;
  localparam logic [3:0] EDGE_MSB   = 4'h4;
  localparam logic [3:0] EDGE_LAST  = 4'hf;

  // Reset values and first trial code
  localparam logic [CTRL_W-1:0] CTRL_RST = 12'h000;
  localparam logic [WORD_W-1:0] MASK_RST = 16'h0000;
  localparam logic [RES_W-1:0]  DAC_MSB  = 12'h800;
  localparam logic [RES_W-1:0]  DAC_RST  = 12'h000;

  typedef enum logic [1:0] {
    ACS_SINGLE,
    ACS_MASK_LOAD,
    ACS_MASK_RUN,
    ACS_CONSEC
  } acs_mode_type;
endpackage : acs_pkg

// File: verilog/acs_pick_if.sv
`timescale 1ns/1ps
interface acs_pick_if;
  logic [15:0] mask;
  logic [3:0]  cur;
  logic [3:0]  next;
  logic        found;
  modport req  (output mask, output cur, input next, input found);
  modport pick (input mask, input cur, output next, output found);
endinterface : acs_pick_if

// File: verilog/acs_sync.sv
`timescale 1ns/1ps
module acs_sync (
  input  wire logic clk_sys_in,
  input  wire logic srst_in,
  input  wire logic cen_in,
  input  wire logic async_in,
  output logic      sync_out
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic q;
  } acs_sync_type;

  acs_sync_type r;
  acs_sync_type next_r;

  // Output follows only once the second and third stages agree
  always_comb begin
    next_r    = r;
    next_r.s1 = async_in;
    next_r.s2 = r.s1;
    next_r.s3 = r.s2;
    if (r.s2 == r.s3) begin
      next_r.q = r.s3;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      r <= '0;
    end else if (cen_in) begin
      r <= next_r;
    end
  end

  assign sync_out = r.q;
endmodule : acs_sync

// File: verilog/acs_pick.sv
`timescale 1ns/1ps
module acs_pick (
  acs_pick_if.pick pk
);
  logic [15:0] en;

  // Mask bit 15 enables channel 0, bit 0 channel 15
  genvar c;
  generate
    for (c = 0; c < 16; c++) begin : g_en
      assign en[c] = pk.mask[15-c];
    end
  endgenerate

  // Lowest enabled channel above cur, else lowest enabled overall
  always_comb begin
    logic       hit;
    logic [3:0] low;
    hit      = 1'b0;
    low      = 4'h0;
    pk.next  = pk.cur;
    pk.found = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      if (en[i]) begin
        low = 4'(i);
        pk.found = 1'b1;
        if (4'(i) > pk.cur) begin
          pk.next = 4'(i);
          hit = 1'b1;
        end
      end
    end
    if (!hit) begin
      pk.next = low;
    end
  end
endmodule : acs_pick

// File: verilog/acs_seq_top.sv
`timescale 1ns/1ps
// Function
// - Single mode converts channel from address field
// - Control bit 1 selects input span
// - Control bit 0 selects binary or twos complement
// - Code step is reference over 4096
// - Shift out four address bits, twelve result
// - Step channel once per serial transfer
// - First transfer after mask: lowest set channel
// - Later transfers: next higher masked channel
// - Wrap to lowest masked channel, repeat
// - Write with bits 1,0 keeps sequence running
// - Any other auto/mask combination ends sequence
// - Both bits set: channels 0 to address, repeat
// - Serial clock drives shift and conversion
// - Both bits clear: no sequencing
// - Bits 0,1: next word loads mask
// - Mask MSB first, bit 15 is channel 0
// - Write bit set loads first 12 bits
module acs_seq_top (
  input  wire logic        clk_sys_in,
  input  wire logic        srst_in,
  input  wire logic        cen_in,
  input  wire logic        sclk_in,
  input  wire logic        cs_n_in,
  input  wire logic        din_in,
  input  wire logic        comp_in,
  output logic             dout_out,
  output logic             dout_oe_out,
  output logic [11:0]      dac_code_out,
  output logic [3:0]       mux_sel_out,
  output logic             range_out,
  output logic [1:0]       power_mode_out,
  output logic             seq_active_out
);
  // System-side sequencer state
  typedef struct packed {
    logic [acs_pkg::CTRL_W-1:0] ctrl;
    logic [acs_pkg::WORD_W-1:0] mask;
    acs_pkg::acs_mode_type      mode;
    logic [acs_pkg::CH_W-1:0]   ch_next;
    logic                       rdy_d;
    logic                       seq_active;
  } acs_sys_type;

  // Link-side frame state, cleared while chip select is high
  typedef struct packed {
    logic [3:0]                 cnt;
    logic                       done;
    logic                       oe;
    logic                       dout;
    logic [acs_pkg::CH_W-1:0]   ch;
    logic                       coding;
    logic [acs_pkg::RES_W-1:0]  dac;
    logic [acs_pkg::WORD_W-1:0] sh;
  } acs_link_type;

  localparam acs_sys_type SYS_RST = '{
    ctrl:       acs_pkg::CTRL_RST,
    mask:       acs_pkg::MASK_RST,
    mode:       acs_pkg::ACS_SINGLE,
    ch_next:    4'h0,
    rdy_d:      1'b0,
    seq_active: 1'b0
  };

  localparam acs_link_type LINK_RST = '{
    cnt:    4'h0,
    done:   1'b0,
    oe:     1'b0,
    dout:   1'b0,
    ch:     4'h0,
    coding: 1'b0,
    dac:    acs_pkg::DAC_RST,
    sh:     16'h0000
  };

  acs_sys_type                s;
  acs_sys_type                next_s;
  acs_link_type               lf;
  acs_link_type               next_lf;
  logic [acs_pkg::WORD_W-1:0] hold_word;
  logic                       rdy_sync;
  logic                       rdy_rise;
  logic [3:0]                 bit_idx;

  acs_pick_if pk ();

  acs_pick u_pick (
    .pk (pk)
  );

  // Word-ready level crosses into the system clock
  acs_sync u_rdy_sync (
    .clk_sys_in (clk_sys_in),
    .srst_in    (srst_in),
    .cen_in     (cen_in),
    .async_in   (lf.done),
    .sync_out   (rdy_sync)
  );

  assign rdy_rise = rdy_sync & ~s.rdy_d;
  assign bit_idx  = 4'hf - lf.cnt;

  // Link logic: one falling serial clock edge per bit
  always_comb begin
    next_lf = lf;
    if (!lf.done) begin
      next_lf.sh = {lf.sh[14:0], din_in};
      next_lf.oe = 1'b1;
      if (lf.cnt == acs_pkg::EDGE_FIRST) begin
        // Channel and coding are static between frames
        next_lf.ch     = s.ch_next;
        next_lf.coding = s.ctrl[acs_pkg::CODING_BIT - acs_pkg::CTRL_LO];
        next_lf.dout   = s.ch_next[3];
      end else if (lf.cnt < acs_pkg::EDGE_MSB) begin
        next_lf.dout = lf.ch[2'(4'h3 - lf.cnt)];
      end else begin
        // One comparator decision per edge, MSB first
        next_lf.dac[bit_idx] = comp_in;
        if (bit_idx != 4'h0) begin
          next_lf.dac[bit_idx - 4'h1] = 1'b1;
        end
        if (lf.cnt == acs_pkg::EDGE_MSB) begin
          next_lf.dout = comp_in ^ ~lf.coding;
        end else begin
          next_lf.dout = comp_in;
        end
      end
      if (lf.cnt == acs_pkg::EDGE_TRIAL) begin
        next_lf.dac = acs_pkg::DAC_MSB;
      end
      if (lf.cnt == acs_pkg::EDGE_LAST) begin
        next_lf.done = 1'b1;
      end else begin
        next_lf.cnt = lf.cnt + 4'h1;
      end
    end
  end

  // Chip select high is the frame's own clear; clock may be stopped then
  always_ff @(negedge sclk_in or posedge cs_n_in) begin
    if (cs_n_in) begin
      lf <= LINK_RST;
    end else begin
      lf <= next_lf;
    end
  end

  // Whole word kept past chip select, read once ready is seen
  always_ff @(negedge sclk_in) begin
    if (!cs_n_in && !lf.done && lf.cnt == acs_pkg::EDGE_LAST) begin
      hold_word <= {lf.sh[14:0], din_in};
    end
  end

  // Mask search: a fresh mask starts above the top channel
  always_comb begin
    if (s.mode == acs_pkg::ACS_MASK_LOAD) begin
      pk.mask = hold_word;
      pk.cur  = 4'hf;
    end else begin
      pk.mask = s.mask;
      pk.cur  = s.ch_next;
    end
  end

  // Sequencer: acts once per received word
  always_comb begin
    logic       do_adv;
    logic [3:0] last_ch;
    logic [1:0] sel;
    do_adv       = 1'b0;
    last_ch      = 4'h0;
    sel          = {hold_word[acs_pkg::AUTO_BIT], hold_word[acs_pkg::SHADOW_BIT]};
    next_s       = s;
    next_s.rdy_d = rdy_sync;
    if (rdy_rise) begin
      if (s.mode == acs_pkg::ACS_MASK_LOAD) begin
        next_s.mask = hold_word;
        if (pk.found) begin
          next_s.mode    = acs_pkg::ACS_MASK_RUN;
          next_s.ch_next = pk.next;
        end else begin
          next_s.mode = acs_pkg::ACS_SINGLE;
        end
      end else if (hold_word[acs_pkg::WR_BIT]) begin
        next_s.ctrl = hold_word[acs_pkg::WORD_W-1:acs_pkg::CTRL_LO];
        case (sel)
          2'b10: begin
            // Other fields change, running sequence goes on
            if (s.mode == acs_pkg::ACS_MASK_RUN || s.mode == acs_pkg::ACS_CONSEC) begin
              do_adv = 1'b1;
            end else begin
              next_s.ch_next = hold_word[acs_pkg::ADDR_HI:acs_pkg::ADDR_LO];
            end
          end
          2'b01: begin
            next_s.mode    = acs_pkg::ACS_MASK_LOAD;
            next_s.ch_next = hold_word[acs_pkg::ADDR_HI:acs_pkg::ADDR_LO];
          end
          2'b11: begin
            next_s.mode    = acs_pkg::ACS_CONSEC;
            next_s.ch_next = 4'h0;
          end
          default: begin
            next_s.mode    = acs_pkg::ACS_SINGLE;
            next_s.ch_next = hold_word[acs_pkg::ADDR_HI:acs_pkg::ADDR_LO];
          end
        endcase
      end else if (s.mode == acs_pkg::ACS_MASK_RUN || s.mode == acs_pkg::ACS_CONSEC) begin
        do_adv = 1'b1;
      end
    end
    // Step after each transfer; in single mode the address holds
    if (do_adv) begin
      last_ch = next_s.ctrl[acs_pkg::ADDR_HI-acs_pkg::CTRL_LO:acs_pkg::ADDR_LO-acs_pkg::CTRL_LO];
      if (s.mode == acs_pkg::ACS_CONSEC) begin
        if (s.ch_next >= last_ch) begin
          next_s.ch_next = 4'h0;
        end else begin
          next_s.ch_next = s.ch_next + 4'h1;
        end
      end else if (pk.found) begin
        next_s.ch_next = pk.next;
      end
    end
    next_s.seq_active = (next_s.mode == acs_pkg::ACS_MASK_RUN) ||
                        (next_s.mode == acs_pkg::ACS_CONSEC);
  end

  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      s <= SYS_RST;
    end else if (cen_in) begin
      s <= next_s;
    end
  end

  // All outputs straight from registers
  assign dout_out       = lf.dout;
  assign dout_oe_out    = lf.oe;
  assign dac_code_out   = lf.dac;
  assign mux_sel_out    = s.ch_next;
  assign range_out      = s.ctrl[acs_pkg::RANGE_BIT - acs_pkg::CTRL_LO];
  assign power_mode_out = s.ctrl[acs_pkg::PM_HI-acs_pkg::CTRL_LO:acs_pkg::PM_LO-acs_pkg::CTRL_LO];
  assign seq_active_out = s.seq_active;
endmodule : acs_seq_top

// File: bench/acs_front_model.sv
`timescale 1ns/1ps
module acs_front_model (
  input  wire logic [3:0]  mux_sel_in,
  input  wire logic [11:0] dac_code_in,
  output logic             comp_out
);
  // Channel n sits at code nnn so every result digit tells channels apart
  // Ideal comparator: half-step offset left out so codes land exactly
  assign comp_out = {mux_sel_in, mux_sel_in, mux_sel_in} >= dac_code_in;
endmodule : acs_front_model

// File: bench/acs_seq_top_sva.sv
`timescale 1ns/1ps
module acs_seq_top_sva (
  input wire logic        clk_sys_in,
  input wire logic        srst_in,
  input wire logic        cen_in,
  input wire logic        sclk_in,
  input wire logic        cs_n_in,
  input wire logic        comp_in,
  input wire logic        dout_out,
  input wire logic        dout_oe_out,
  input wire logic [11:0] dac_code_out,
  input wire logic [3:0]  mux_sel_out,
  input wire logic        range_out,
  input wire logic [1:0]  power_mode_out,
  input wire logic        seq_active_out
);
  logic [4:0] cnt;
  // Falling edges seen in this frame; cs_n high clears it as in the link
  always_ff @(negedge sclk_in or posedge cs_n_in) begin
    if (cs_n_in) cnt <= 5'h00;
    else if (cnt != 5'h10) cnt <= cnt + 5'h01;
  end
  chk_reset_values: assert property (@(posedge clk_sys_in) srst_in && cen_in |=>
    mux_sel_out == 4'h0 && !range_out && power_mode_out == 2'h0 && !seq_active_out)
    else $error("sys outputs not cleared by reset");
  chk_oe_released: assert property (@(posedge clk_sys_in) cs_n_in ##1 cs_n_in |->
    !dout_oe_out) else $error("output enable high while deselected");
  chk_dac_idle: assert property (@(posedge clk_sys_in) cs_n_in ##1 cs_n_in |->
    dac_code_out == 12'h000) else $error("trial code not cleared between frames");
  chk_dac_first_trial: assert property (@(negedge sclk_in) disable iff (cs_n_in)
    cnt == 5'h03 |=> dac_code_out == 12'h800) else $error("first trial code wrong");
  chk_dac_bit_decided: assert property (@(negedge sclk_in) disable iff (cs_n_in)
    cnt inside {[4:14]} |=> dac_code_out[15 - $past(cnt)] == $past(comp_in)
    && dac_code_out[14 - $past(cnt)]) else $error("trial bit not decided by comparator");
  chk_addr_shifted: assert property (@(negedge sclk_in) disable iff (cs_n_in)
    cnt inside {[1:4]} |-> dout_out == mux_sel_out[4 - cnt]) else $error("address bit wrong");
  chk_oe_in_frame: assert property (@(negedge sclk_in) disable iff (cs_n_in)
    cnt != 5'h00 |-> dout_oe_out) else $error("output enable low inside frame");
  chk_chan_steady: assert property (@(negedge sclk_in) disable iff (cs_n_in)
    cnt inside {[1:15]} |-> $stable(mux_sel_out)) else $error("channel moved mid frame");
endmodule : acs_seq_top_sva
bind acs_seq_top acs_seq_top_sva u_sva (.clk_sys_in(clk_sys_in), .srst_in(srst_in),
  .cen_in(cen_in), .sclk_in(sclk_in), .cs_n_in(cs_n_in), .comp_in(comp_in),
  .dout_out(dout_out), .dout_oe_out(dout_oe_out), .dac_code_out(dac_code_out),
  .mux_sel_out(mux_sel_out), .range_out(range_out), .power_mode_out(power_mode_out),
  .seq_active_out(seq_active_out));

// File: bench/adc_channel_sequencer_tb.sv
`timescale 1ns/1ps
module adc_channel_sequencer_tb;
  logic        clk_sys_in, srst_in, cen_in, sclk_in, cs_n_in, din_in, comp_in;
  logic        dout_out, dout_oe_out, range_out, seq_active_out;
  logic [11:0] dac_code_out;
  logic [3:0]  mux_sel_out;
  logic [1:0]  power_mode_out;
  int          err_count, checks_done;

  acs_seq_top uut (.clk_sys_in(clk_sys_in), .srst_in(srst_in), .cen_in(cen_in),
    .sclk_in(sclk_in), .cs_n_in(cs_n_in), .din_in(din_in), .comp_in(comp_in),
    .dout_out(dout_out), .dout_oe_out(dout_oe_out), .dac_code_out(dac_code_out),
    .mux_sel_out(mux_sel_out), .range_out(range_out), .power_mode_out(power_mode_out),
    .seq_active_out(seq_active_out));
  acs_front_model u_front (.mux_sel_in(mux_sel_out), .dac_code_in(dac_code_out),
    .comp_out(comp_in));

  // System clock, 5 ns
  initial begin
    clk_sys_in = 1'b0;
    forever #2.5 clk_sys_in = ~clk_sys_in;
  end

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : complete_run

  // Control word: am is {auto cycle, mask select}, power bits kept at normal
  function automatic logic [15:0] ctl(input logic [1:0] am, input logic [3:0] a,
                                      input logic r, input logic c);
    return {1'b1, am[1], a, 2'b11, am[0], 1'b0, r, c, 4'h0};
  endfunction : ctl

  // One 16-edge transfer; serial clock at 48 ns runs only inside the frame
  task automatic frame(input logic [15:0] w, input logic [3:0] ch, input logic cod);
    logic [15:0] got;
    logic [11:0] v;
    v = {ch, ch, ch};
    @(posedge clk_sys_in);
    cs_n_in <= 1'b0;
    #33;
    for (int i = 15; i >= 0; i--) begin
      din_in <= w[i];
      #24 sclk_in = 1'b0;
      #24 sclk_in = 1'b1;
      got[i] = dout_out;
    end
    // Hold select long enough for the word to cross into the sys domain
    #40;
    @(posedge clk_sys_in);
    cs_n_in <= 1'b1;
    din_in <= 1'b0;
    repeat (16) @(posedge clk_sys_in);
    check("word", got, {ch, v ^ {~cod, 11'h000}});
  endtask : frame

  task automatic t_single();
    frame(ctl(2'b00, 4'h5, 1'b1, 1'b1), 4'h0, 1'b0);
    check("range", 16'(range_out), 16'h0001);
    check("chan", 16'(mux_sel_out), 16'h0005);
    check("power", 16'(power_mode_out), 16'h0003);
    frame(ctl(2'b00, 4'h9, 1'b0, 1'b0), 4'h5, 1'b1);
    frame(16'h0000, 4'h9, 1'b0);
    check("seq", 16'(seq_active_out), 16'h0000);
  endtask : t_single

  task automatic t_mask();
    logic [3:0] order [5] = '{4'h2, 4'h5, 4'hb, 4'he, 4'h2};
    frame(ctl(2'b01, 4'h9, 1'b0, 1'b1), 4'h9, 1'b0);
    frame(16'h2412, 4'h9, 1'b1);
    check("seq", 16'(seq_active_out), 16'h0001);
    foreach (order[k]) frame(16'h0000, order[k], 1'b1);
    // Range flips so the write is seen to land while the sequence goes on
    frame(ctl(2'b10, 4'h0, 1'b1, 1'b1), 4'h5, 1'b1);
    check("range", 16'(range_out), 16'h0001);
    frame(ctl(2'b00, 4'h3, 1'b0, 1'b1), 4'hb, 1'b1);
    check("seq", 16'(seq_active_out), 16'h0000);
    frame(16'h0000, 4'h3, 1'b1);
  endtask : t_mask

  task automatic t_consec();
    logic [3:0] order [4] = '{4'h0, 4'h1, 4'h2, 4'h0};
    frame(ctl(2'b11, 4'h2, 1'b0, 1'b1), 4'h3, 1'b1);
    check("seq", 16'(seq_active_out), 16'h0001);
    foreach (order[k]) frame(16'h0000, order[k], 1'b1);
  endtask : t_consec

  // Reset in mid-run, while a consecutive sequence is active
  task automatic t_reset();
    check("seq", 16'(seq_active_out), 16'h0001);
    srst_in <= 1'b1;
    repeat (4) @(posedge clk_sys_in);
    srst_in <= 1'b0;
    repeat (4) @(posedge clk_sys_in);
    check("reset seq", 16'(seq_active_out), 16'h0000);
    check("reset chan", 16'(mux_sel_out), 16'h0000);
    check("reset power", 16'(power_mode_out), 16'h0000);
    frame(16'h0000, 4'h0, 1'b0);
  endtask : t_reset

  // Enable low: the link still answers but the word is never taken
  task automatic t_freeze();
    cen_in <= 1'b0;
    frame(ctl(2'b00, 4'h6, 1'b1, 1'b1), 4'h0, 1'b0);
    check("frozen chan", 16'(mux_sel_out), 16'h0000);
    check("frozen range", 16'(range_out), 16'h0000);
    cen_in <= 1'b1;
    // Auto/mask 1,0 outside a sequence acts as a plain channel write
    frame(ctl(2'b10, 4'h7, 1'b1, 1'b1), 4'h0, 1'b0);
    check("chan", 16'(mux_sel_out), 16'h0007);
    check("range", 16'(range_out), 16'h0001);
    check("seq", 16'(seq_active_out), 16'h0000);
    frame(16'h0000, 4'h7, 1'b1);
  endtask : t_freeze

  // Watchdog: the whole run needs about 21 us
  initial begin
    #100000;
    err_count++;
    complete_run();
  end

  initial begin
    srst_in = 1'b1;
    cen_in = 1'b1;
    sclk_in = 1'b1;
    cs_n_in = 1'b0;
    din_in = 1'b0;
    err_count = 0;
    checks_done = 0;
    // Select rises after time zero so the link clear sees a real edge
    @(posedge clk_sys_in);
    cs_n_in <= 1'b1;
    repeat (7) @(posedge clk_sys_in);
    srst_in <= 1'b0;
    repeat (8) @(posedge clk_sys_in);
    check("reset chan", 16'(mux_sel_out), 16'h0000);
    t_single();
    t_mask();
    t_consec();
    t_reset();
    t_freeze();
    complete_run();
  end
endmodule : adc_channel_sequencer_tb
